// ### verilog/msi_pkg.sv
/*
 Package for the modem status and interrupt logic: register offsets, bit
 positions, reset values, task codes and the carrier structs.
 Assumes the modem core supplies task and event strobes on ref_clk.
*/
package msi_pkg;

   // Register offsets on the 8-bit host port
   localparam logic [4:0] MSI_OFS_PRIMARY_STATUS = 5'h01;
   localparam logic [4:0] MSI_OFS_OPERATING_MODE = 5'h03;
   localparam logic [4:0] MSI_OFS_QUALITY        = 5'h02;
   localparam logic [4:0] MSI_OFS_SECOND_STATUS  = 5'h0A;

   // Operating mode bit positions
   localparam int MSI_MODE_IRQ_OE  = 7;
   localparam int MSI_MODE_TX_RX   = 5;
   localparam int MSI_MODE_SCR_EN  = 4;
   localparam int MSI_MODE_LOCK_EN = 3;
   localparam int MSI_MODE_QUAL_EN = 2;
   localparam int MSI_MODE_ADC_EN  = 1;
   localparam int MSI_MODE_DAC_EN  = 0;

   // Primary status bit positions
   localparam int MSI_ST_IRQ    = 7;
   localparam int MSI_ST_BUFFER_FREE_FLAG  = 6;
   localparam int MSI_ST_IEMPTY = 5;
   localparam int MSI_ST_OVF    = 4;
   localparam int MSI_ST_CHKERR = 3;
   localparam int MSI_ST_QRDY   = 2;
   localparam int MSI_ST_ORIGIN = 1;
   localparam int MSI_ST_PKT    = 0;

   // Second status bits able to interrupt (7,3,2,1,0)
   localparam logic [7:0] MSI_SEC_IRQ_MASK = 8'h8F;

   // Reset values
   localparam logic [7:0] MSI_MODE_RESET = 8'h00;
   localparam logic       MSI_FLAG_SET   = 1'b1;

   // Command task codes (low nibble of command)
   localparam logic [3:0] MSI_TASK_NULL       = 4'h0;
   localparam logic [3:0] MSI_TASK_RESET      = 4'hF;
   localparam logic [3:0] MSI_TASK_SCR_OUT    = 4'hE;
   localparam logic [3:0] MSI_TASK_LONG_RX    = 4'h1;
   localparam logic [3:0] MSI_TASK_SHORT_RX   = 4'h2;
   localparam logic [3:0] MSI_TASK_SHORT_TX   = 4'h3;
   localparam logic [3:0] MSI_TASK_LONG_TX    = 4'h4;
   localparam logic [3:0] MSI_TASK_SYNC_A     = 4'h5;
   localparam logic [3:0] MSI_TASK_SYNC_B     = 4'h6;

   // Mid-level bias code for the transmit filter path
   localparam logic [7:0] MSI_BIAS_LEVEL = 8'h80;

   // Synchroniser stages for pin inputs
   localparam int MSI_SYNC_STAGES = 2;

   // Host bus access carrier
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [4:0] addr;
      logic [7:0] wdata;
   } msi_bus_t;

   // Core event strobes, one cycle each
   typedef struct packed {
      logic       task_done;
      logic       tx_ready;
      logic       ibuf_low;
      logic       task_late;
      logic       check_done;
      logic       check_err;
      logic       qual_done;
      logic       sync_done;
      logic [2:0] sync_pre;
      logic       active;
      logic [3:0] task_code;
   } msi_core_t;

endpackage : msi_pkg

// ### verilog/msi_sync.sv
/*
 Two-flop synchroniser for pin level inputs.
 Assumes the input is a slow level with no timing relation to ref_clk.
*/
`timescale 1ns/1ps
module msi_sync
   import msi_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_reg;

   initial begin
      if (WIDTH < 1) $error("msi_sync WIDTH must be at least 1");
   end

   // First stage read only by the second
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         dout     <= '0;
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end

endmodule : msi_sync

// ### verilog/msi_status_irq.sv
/*
 Status flags, operating mode register and interrupt request of the modem.
 Assumes host bus strobes and core event strobes are synchronous to ref_clk,
 and that the packet detect and lock-lost levels arrive from pins.
*/
// Summary of operation
// - Scrambler runs only in scrambled-output and data block tasks if enabled.
// - Lock-lost rise sets second status bit and request when enabled.
// - In receive, quality reading sets ready flag and request when enabled.
// - Mode bits 1 and 0 power main ADC and DAC.
// - Buffer-free or interleave-empty rise requests, except reset or mode change.
// - Quality, overflow, packet and second status bit (7,3,2,1,0) rises also request.
// - Request clears on reading its causing status register.
// - Interrupt pin low while request and output enable are set.
// - Buffer-free clears on any task but null, reset, scrambled-output.
// - Buffer-free rises with request when tx ready or rx task done.
// - Reset task or mode change sets buffer-free quietly.
// - Interleave-empty rises in transmit below two bits; zero in receive.
// - Reset or mode change sets interleave-empty quietly; any task but null, reset, scrambled-output clears.
// - Overflow rises on late task in receive; read, reset, change clear.
// - Check-error updates after CRC or FEC check; reset or change clear.
// - Quality-ready rises on reading done, clears on quality read.
// - Quality-ready may rise right after reset or mode drop.
// - Origin flag set by 011 preamble, cleared by 100, one error.
// - Packet-present mirrors detector, zero in transmit.
// - Select bit 1 is transmit; any change cancels the task.
`timescale 1ns/1ps
module msi_status_irq
   import msi_pkg::*;
#(
   parameter int SEC_WIDTH = 8
) (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire msi_bus_t   host_bus,
   output logic      [7:0] host_rdata,
   input  wire msi_core_t  core_evt,
   input  wire logic       baseband_en,
   input  wire logic       pkt_detect_en,
   input  wire logic       packet_pin,
   input  wire logic       lock_lost_pin,
   input  wire logic [7:0] quality_value,
   input  wire logic [SEC_WIDTH-1:0] sec_events,
   output logic            interrupt_out_low,
   output logic            scrambler_run,
   output logic            adc_power,
   output logic            dac_power,
   output logic            tx_mode,
   output logic            task_cancel,
   output logic            bias_drive,
   output logic      [7:0] bias_level
);

   initial begin
      if (SEC_WIDTH != 8) $error("msi_status_irq SEC_WIDTH must be 8");
   end

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] mode_reg;
   logic       irq_reg, irq_next;
   logic       irq_sec_reg, irq_sec_next;
   logic       buffer_free_flag_reg, buffer_free_flag_next;
   logic       iempty_reg, iempty_next;
   logic       ovf_reg, ovf_next;
   logic       chkerr_reg, chkerr_next;
   logic       qrdy_reg, qrdy_next;
   logic       origin_reg, origin_next;
   logic       pkt_prev_reg;
   logic       bb_prev_reg;
   logic [7:0] sec_reg, sec_next;
   logic       scr_task_reg;
   logic [1:0] pins_sync;

   // One-error-tolerant pattern match on three bits
   function automatic logic near_match(input logic [2:0] v,
                                       input logic [2:0] p);
      logic [2:0] d;
      d = v ^ p;
      near_match = (d == 3'h0) || (d == 3'h1) || (d == 3'h2) ||
                   (d == 3'h4);
   endfunction : near_match

   // Task that starts data movement
   function automatic logic is_real_task(input logic [3:0] t);
      is_real_task = (t != MSI_TASK_NULL) && (t != MSI_TASK_RESET) &&
                     (t != MSI_TASK_SCR_OUT);
   endfunction : is_real_task

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   msi_sync #(
      .WIDTH (2)
   ) u_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .din     ({packet_pin, lock_lost_pin}),
      .dout    (pins_sync)
   );

   wire packet_s    = pins_sync[1];
   wire lock_lost_s = pins_sync[0];

   ////////////////////////////////////////////////////////////////////////
   // Host access decode
   wire cmd_is_mode   = host_bus.addr == MSI_OFS_OPERATING_MODE;
   wire rd_primary    = host_bus.rd && host_bus.addr == MSI_OFS_PRIMARY_STATUS;
   wire rd_quality    = host_bus.rd && host_bus.addr == MSI_OFS_QUALITY;
   wire rd_second     = host_bus.rd && host_bus.addr == MSI_OFS_SECOND_STATUS;
   wire wr_mode       = host_bus.wr && cmd_is_mode;
   wire [3:0] task_w  = core_evt.task_code;
   wire task_new      = core_evt.active;
   wire task_reset    = task_new && task_w == MSI_TASK_RESET;
   wire task_real     = task_new && is_real_task(task_w);

   // Mode change detection
   wire txrx_change   = wr_mode &&
                        host_bus.wdata[MSI_MODE_TX_RX] !=
                        mode_reg[MSI_MODE_TX_RX];
   wire bb_change     = baseband_en != bb_prev_reg;
   wire mode_quiet    = task_reset || txrx_change || bb_change;
   wire is_tx         = mode_reg[MSI_MODE_TX_RX];
   wire is_rx         = !is_tx;

   ////////////////////////////////////////////////////////////////////////
   // Flag next values
   always_comb begin
      buffer_free_flag_next = buffer_free_flag_reg;
      if (task_real) buffer_free_flag_next = 1'b0;
      if ((is_tx && core_evt.tx_ready) || (is_rx && core_evt.task_done))
         buffer_free_flag_next = 1'b1;
      if (mode_quiet) buffer_free_flag_next = MSI_FLAG_SET;

      iempty_next = iempty_reg;
      if (task_real) iempty_next = 1'b0;
      if (is_tx && core_evt.ibuf_low) iempty_next = 1'b1;
      if (mode_quiet) iempty_next = MSI_FLAG_SET;

      ovf_next = ovf_reg;
      if (rd_primary) ovf_next = 1'b0;
      if (is_rx && core_evt.task_late) ovf_next = 1'b1;
      if (mode_quiet) ovf_next = 1'b0;

      chkerr_next = chkerr_reg;
      if (is_rx && core_evt.check_done)
         chkerr_next = core_evt.check_err;
      if (mode_quiet) chkerr_next = 1'b0;

      qrdy_next = qrdy_reg;
      if (rd_quality) qrdy_next = 1'b0;
      if (is_rx && core_evt.qual_done) qrdy_next = 1'b1;

      origin_next = origin_reg;
      if (is_rx && core_evt.sync_done) begin
         if (near_match(core_evt.sync_pre, 3'h3)) origin_next = 1'b1;
         else if (near_match(core_evt.sync_pre, 3'h4))
            origin_next = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt causes
   wire buffer_free_flag_rise  = buffer_free_flag_next && !buffer_free_flag_reg && !mode_quiet;
   wire iempty_rise = iempty_next && !iempty_reg && !mode_quiet;
   wire qrdy_rise   = qrdy_next && !qrdy_reg &&
                      mode_reg[MSI_MODE_QUAL_EN] && is_rx;
   wire ovf_rise    = ovf_next && !ovf_reg;
   wire pkt_now     = packet_s && is_rx;
   wire pkt_rise    = pkt_now && !pkt_prev_reg && pkt_detect_en;
   wire [7:0] sec_in = {sec_events[7:1],
                        sec_events[0] | lock_lost_s};
   wire [7:0] sec_rise = sec_in & ~sec_reg & MSI_SEC_IRQ_MASK;
   wire lock_irq    = sec_in[0] && !sec_reg[0] &&
                      mode_reg[MSI_MODE_LOCK_EN];
   wire sec_cause   = (|sec_rise[7:1]) || lock_irq;
   wire pri_cause   = buffer_free_flag_rise || iempty_rise || qrdy_rise ||
                      ovf_rise || pkt_rise;

   // Second status holds until read; set wins
   always_comb begin
      sec_next = rd_second ? 8'h00 : sec_reg;
      sec_next = sec_next | sec_in;
   end

   // Request clears on its register read, set wins
   always_comb begin
      irq_sec_next = irq_sec_reg;
      irq_next     = irq_reg;
      if (rd_primary && !irq_sec_reg) irq_next = 1'b0;
      if (rd_second) begin
         irq_sec_next = 1'b0;
         irq_next     = 1'b0;
      end
      if (sec_cause) begin
         irq_sec_next = 1'b1;
         irq_next     = 1'b1;
      end
      if (pri_cause) irq_next = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         buffer_free_flag_reg   <= MSI_FLAG_SET;
         iempty_reg  <= MSI_FLAG_SET;
         ovf_reg     <= 1'b0;
         chkerr_reg  <= 1'b0;
         qrdy_reg    <= 1'b0;
         origin_reg  <= 1'b0;
         irq_reg     <= 1'b0;
         irq_sec_reg <= 1'b0;
         sec_reg     <= 8'h00;
      end else begin
         buffer_free_flag_reg   <= buffer_free_flag_next;
         iempty_reg  <= iempty_next;
         ovf_reg     <= ovf_next;
         chkerr_reg  <= chkerr_next;
         qrdy_reg    <= qrdy_next;
         origin_reg  <= origin_next;
         irq_reg     <= irq_next;
         irq_sec_reg <= irq_sec_next;
         sec_reg     <= sec_next;
      end
   end

   // Mode register and edge history
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mode_reg     <= MSI_MODE_RESET;
         pkt_prev_reg <= 1'b0;
         bb_prev_reg  <= 1'b0;
      end else begin
         if (wr_mode) mode_reg <= host_bus.wdata;
         pkt_prev_reg <= pkt_now;
         bb_prev_reg  <= baseband_en;
      end
   end

   // Scrambler runs only in its tasks
   wire scr_task = task_w == MSI_TASK_SCR_OUT || task_w == MSI_TASK_LONG_RX
                   || task_w == MSI_TASK_SHORT_RX
                   || task_w == MSI_TASK_SHORT_TX
                   || task_w == MSI_TASK_LONG_TX;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) scr_task_reg <= 1'b0;
      else       scr_task_reg <= core_evt.active && scr_task && !txrx_change;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data and outputs
   wire [7:0] status_word = {irq_reg, buffer_free_flag_reg, iempty_reg & is_tx,
                             ovf_reg & is_rx, chkerr_reg & is_rx,
                             qrdy_reg, origin_reg & is_rx,
                             pkt_prev_reg};

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) host_rdata <= 8'h00;
      else if (rd_primary) host_rdata <= status_word;
      else if (rd_quality) host_rdata <= is_rx ? quality_value : 8'h00;
      else if (rd_second) host_rdata <= sec_reg;
      else host_rdata <= 8'h00;
   end

   assign interrupt_out_low = !(irq_reg && mode_reg[MSI_MODE_IRQ_OE]);
   assign scrambler_run = mode_reg[MSI_MODE_SCR_EN] && scr_task_reg;
   assign adc_power     = mode_reg[MSI_MODE_ADC_EN];
   assign dac_power     = mode_reg[MSI_MODE_DAC_EN];
   assign tx_mode       = is_tx;
   assign task_cancel   = txrx_change;
   assign bias_drive    = is_tx && iempty_reg;
   assign bias_level    = MSI_BIAS_LEVEL;

endmodule : msi_status_irq

// ### verif/msi_chk.sv
/* Port assertions for msi_status_irq.
   Assumes one ref_clk domain and the bind below. */
`timescale 1ns/1ps
module msi_chk
   import msi_pkg::*;
#(parameter int SEC_WIDTH = 8) (
   input wire logic                 ref_clk,
   input wire logic                 nrst,
   input wire msi_bus_t             host_bus,
   input wire logic [7:0]           host_rdata,
   input wire msi_core_t            core_evt,
   input wire logic                 baseband_en,
   input wire logic                 pkt_detect_en,
   input wire logic                 packet_pin,
   input wire logic                 lock_lost_pin,
   input wire logic [7:0]           quality_value,
   input wire logic [SEC_WIDTH-1:0] sec_events,
   input wire logic                 interrupt_out_low,
   input wire logic                 scrambler_run,
   input wire logic                 adc_power,
   input wire logic                 dac_power,
   input wire logic                 tx_mode,
   input wire logic                 task_cancel,
   input wire logic                 bias_drive,
   input wire logic [7:0]           bias_level
);
   logic oe_reg;
   logic scr_reg;
   wire  mode_wr = host_bus.wr && host_bus.addr == MSI_OFS_OPERATING_MODE;
   wire  st_rd = host_bus.rd && host_bus.addr == MSI_OFS_PRIMARY_STATUS;
   // Shadow of the pin enable and scramble enable bits
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         oe_reg  <= 1'b0;
         scr_reg <= 1'b0;
      end else if (mode_wr) begin
         oe_reg  <= host_bus.wdata[7];
         scr_reg <= host_bus.wdata[4];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Status read with no overflow cause present
   sequence s_st_rd;
      st_rd && !core_evt.task_late;
   endsequence
   chk_mode_bits: assert property (
      mode_wr |=> tx_mode == $past(host_bus.wdata[5])
         && adc_power == $past(host_bus.wdata[1])
         && dac_power == $past(host_bus.wdata[0]))
      else $error("mode bits not taken");
   chk_cancel_on: assert property (
      mode_wr && host_bus.wdata[5] != tx_mode |-> task_cancel)
      else $error("select change without cancel");
   chk_cancel_cause: assert property (
      task_cancel |-> mode_wr) else $error("stray cancel");
   chk_pin_off: assert property (
      !oe_reg |-> interrupt_out_low) else $error("pin low while disabled");
   chk_bias_mid: assert property (
      bias_drive |-> tx_mode && bias_level == MSI_BIAS_LEVEL)
      else $error("bias wrong");
   chk_scr_gate: assert property (
      scrambler_run |-> scr_reg) else $error("scrambler runs disabled");
   chk_rd_idle: assert property (
      !host_bus.rd |=> host_rdata == 8'h00) else $error("data without read");
   chk_ovf_clear: assert property (
      s_st_rd ##1 !core_evt.task_late ##1 s_st_rd
         |=> !host_rdata[MSI_ST_OVF])
      else $error("overflow survives read");
   chk_tx_zero: assert property (
      st_rd && tx_mode && !mode_wr |=> host_rdata[4:3] == 2'b00
         && host_rdata[1:0] == 2'b00) else $error("rx flags in tx");
   chk_rx_iempty: assert property (
      st_rd && !tx_mode && !mode_wr |=> !host_rdata[MSI_ST_IEMPTY])
      else $error("interleave flag in rx");
   chk_late_irq: assert property (
      core_evt.task_late && !tx_mode && oe_reg && !mode_wr
         |=> !interrupt_out_low) else $error("late task no irq");
endmodule : msi_chk
bind msi_status_irq msi_chk #(.SEC_WIDTH(SEC_WIDTH)) u_chk (
   .ref_clk(ref_clk), .nrst(nrst), .host_bus(host_bus),
   .host_rdata(host_rdata), .core_evt(core_evt), .baseband_en(baseband_en),
   .pkt_detect_en(pkt_detect_en), .packet_pin(packet_pin),
   .lock_lost_pin(lock_lost_pin), .quality_value(quality_value),
   .sec_events(sec_events), .interrupt_out_low(interrupt_out_low),
   .scrambler_run(scrambler_run), .adc_power(adc_power),
   .dac_power(dac_power), .tx_mode(tx_mode), .task_cancel(task_cancel),
   .bias_drive(bias_drive), .bias_level(bias_level));

// ### verif/msi_host.sv
/* Host microcontroller model on the 8-bit register port.
   Assumes ref_clk from the bench; tasks called by the bench. */
`timescale 1ns/1ps
module msi_host
   import msi_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic [7:0] host_rdata,
   output msi_bus_t       host_bus
);
   initial host_bus = '0;
   // One write strobe, then address and data turned over
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk) host_bus <= '{1'b0, 1'b1, a, d};
      @(posedge ref_clk) host_bus <= '{1'b0, 1'b0, ~a, ~d};
      #1;
   endtask : wr
   // One read strobe; data taken the cycle after
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge ref_clk) host_bus <= '{1'b1, 1'b0, a, 8'hA5};
      @(posedge ref_clk) host_bus <= '{1'b0, 1'b0, ~a, 8'h5A};
      #1 d = host_rdata;
   endtask : rd
endmodule : msi_host

// ### verif/msi_status_irq_tb.sv
/* Self-checking bench for msi_status_irq.
   Assumes msi_host as register master and msi_chk bound. */
`timescale 1ns/1ps
module msi_status_irq_tb
   import msi_pkg::*;
;
   logic      ref_clk = 1'b0, nrst = 1'b0, pkt_detect_en = 1'b0;
   logic      packet_pin = 1'b0, lock_lost_pin = 1'b0;
   msi_core_t core_evt = '0;
   msi_bus_t  host_bus;
   logic [7:0] host_rdata, bias_level;
   logic      irq_n, scr_run, adc_on, dac_on, tx_mode, cancel, bias_on;
   int        failures = 0, cmp_count = 0, cycles = 0;
   msi_host host (.ref_clk(ref_clk), .host_rdata(host_rdata),
      .host_bus(host_bus));
   msi_status_irq #(.SEC_WIDTH(8)) DUT (.ref_clk(ref_clk), .nrst(nrst),
      .host_bus(host_bus), .host_rdata(host_rdata), .core_evt(core_evt),
      .baseband_en(1'b1), .pkt_detect_en(pkt_detect_en),
      .packet_pin(packet_pin), .lock_lost_pin(lock_lost_pin),
      .quality_value(8'h5A), .sec_events(8'h00),
      .interrupt_out_low(irq_n), .scrambler_run(scr_run),
      .adc_power(adc_on), .dac_power(dac_on), .tx_mode(tx_mode),
      .task_cancel(cancel), .bias_drive(bias_on), .bias_level(bias_level));
   ////////////////////////////////////////////////////////////////////////
   // Clock and cycle ceiling
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         $display("[FAIL] %0t timeout", $time);
         close_out();
      end
   end
   task automatic chk8(input logic [7:0] g, e, input string w);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, w, g, e);
      end
   endtask : chk8
   task automatic chk1(input logic g, e, input string w);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t %s got %b", $time, w, g);
      end
   endtask : chk1
   task automatic st(input logic [7:0] e, input string w);
      logic [7:0] d;
      host.rd(MSI_OFS_PRIMARY_STATUS, d);
      chk8(d, e, w);
   endtask : st
   // Masked status check, then quality read to drop a stale ready flag
   task automatic settle(input logic [7:0] e);
      logic [7:0] d;
      host.rd(MSI_OFS_PRIMARY_STATUS, d);
      chk8(d & 8'h7B, e, "settle");
      host.rd(MSI_OFS_QUALITY, d);
   endtask : settle
   task automatic pulse(input msi_core_t e);
      @(posedge ref_clk) core_evt <= e;
      @(posedge ref_clk) core_evt <= '0;
      #1;
   endtask : pulse
   task automatic wtask(input logic [3:0] c);
      pulse('{active:1'b1, task_code:c, default:'0});
   endtask : wtask
   task automatic wait4();
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : wait4
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] d;
      st(8'h40, "reset");
      chk1(irq_n, 1'b1, "pin idle");
      host.rd(5'h1F, d);
      chk8(d, 8'h00, "unmapped");
      $display("t_reset done");
   endtask : t_reset
   task automatic t_tx();
      host.wr(MSI_OFS_OPERATING_MODE, 8'hB1);
      settle(8'h60);
      wtask(MSI_TASK_NULL);
      wtask(MSI_TASK_SCR_OUT);
      st(8'h60, "null task");
      wtask(MSI_TASK_LONG_TX);
      chk1(scr_run, 1'b1, "scr on");
      st(8'h00, "tx task");
      pulse('{tx_ready:1'b1, ibuf_low:1'b1, default:'0});
      chk1(irq_n, 1'b0, "tx irq");
      chk1(bias_on, 1'b1, "bias");
      st(8'hE0, "tx flags");
      chk1(irq_n, 1'b1, "tx clr");
      $display("t_tx done");
   endtask : t_tx
   task automatic t_rx();
      host.wr(MSI_OFS_OPERATING_MODE, 8'h82);
      chk1(tx_mode, 1'b0, "rx mode");
      settle(8'h40);
      pulse('{task_late:1'b1, default:'0});
      chk1(irq_n, 1'b0, "late irq");
      st(8'hD0, "overflow");
      st(8'h40, "ovf clr");
      wtask(MSI_TASK_LONG_RX);
      chk1(scr_run, 1'b0, "scr off");
      st(8'h00, "rx task");
      pulse('{task_done:1'b1, default:'0});
      st(8'hC0, "rx done");
      $display("t_rx done");
   endtask : t_rx
   task automatic t_check();
      pulse('{check_done:1'b1, check_err:1'b1, default:'0});
      st(8'h48, "chk err");
      st(8'h48, "chk kept");
      pulse('{check_done:1'b1, default:'0});
      st(8'h40, "chk ok");
      pulse('{check_done:1'b1, check_err:1'b1, default:'0});
      wtask(MSI_TASK_RESET);
      settle(8'h40);
      $display("t_check done");
   endtask : t_check
   task automatic t_quality();
      logic [7:0] d;
      host.wr(MSI_OFS_OPERATING_MODE, 8'h86);
      pulse('{qual_done:1'b1, default:'0});
      chk1(irq_n, 1'b0, "dq irq");
      st(8'hC4, "dq ready");
      host.rd(MSI_OFS_QUALITY, d);
      st(8'h40, "dq clr");
      host.wr(MSI_OFS_OPERATING_MODE, 8'h82);
      pulse('{qual_done:1'b1, default:'0});
      st(8'h44, "dq quiet");
      host.rd(MSI_OFS_QUALITY, d);
      $display("t_quality done");
   endtask : t_quality
   task automatic t_origin();
      logic [2:0] pre [4] = '{3'b011, 3'b100, 3'b001, 3'b110};
      for (int i = 0; i < 4; i++) begin
         pulse('{sync_done:1'b1, sync_pre:pre[i], default:'0});
         st(i[0] ? 8'h40 : 8'h42, "origin");
      end
      $display("t_origin done");
   endtask : t_origin
   task automatic t_events();
      logic [7:0] d;
      host.wr(MSI_OFS_OPERATING_MODE, 8'h8A);
      pkt_detect_en <= 1'b1;
      packet_pin <= 1'b1;
      wait4();
      st(8'hC1, "packet");
      @(posedge ref_clk) packet_pin <= 1'b0;
      lock_lost_pin <= 1'b1;
      wait4();
      chk1(irq_n, 1'b0, "lock irq");
      st(8'hC0, "lock st");
      st(8'hC0, "lock kept");
      host.rd(MSI_OFS_SECOND_STATUS, d);
      chk8(d & 8'h01, 8'h01, "lock bit");
      st(8'h40, "lock clr");
      $display("t_events done");
   endtask : t_events
   task automatic close_out();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   // Reset, then the scenarios in order
   initial begin
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_tx();
      t_rx();
      t_check();
      t_quality();
      t_origin();
      t_events();
      close_out();
   end
endmodule : msi_status_irq_tb
